/* ctpw_timer.sv */
// Summary of operation
// - Two bytes chain into one 16-bit up-counter
// - Pulse mode: duty match toggles flop, counting continues
// - Pulse mode: period match toggles, clears, raises interrupt
// - Flop loads initial level in pulse mode only; reset clears it
// - Pulse pin is inverse of flop
// - Compare writes act at once, unbuffered
// - Stopping holds pin; level changes after stop
// - Warm-up compares upper period byte only
// - Warm-up match clears counter, raises interrupt
// - Slow clock warm-up times follow compare value
// - Fast clock warm-up times follow compare value
//
// Cascaded 16-bit timer: pulse-generation and warm-up counter modes.
// Assumes internal tick from a same-clock prescaler, pin event asynchronous.
`timescale 1ns/100ps
`include "ctpw_params.svh"

module ctpw_timer
    import ctpw_pkg::*;
#(
    parameter int CNT_W = `CTPW_CNT_W
) (
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    // Control bits
    input  wire ctpw_ctrl_s ctrl_in,
    // Compare registers, written low byte first by software
    input  wire ctpw_cmp_s  duty_compare_in,
    input  wire ctpw_cmp_s  period_compare_in,
    // Count sources
    input  wire logic       int_tick_in,
    input  wire logic       event_input_pin_in,
    // Outputs
    output logic            pulse_output_n_out,
    output logic            timer_match_irq_out,
    output logic [CNT_W-1:0] count_out
);

    ctpw_state_s st_q;
    ctpw_state_s st_d;
    logic        ev_fall;
    logic        step;
    logic [CNT_W-1:0] duty_v;
    logic [CNT_W-1:0] per_v;
    logic        duty_hit;
    logic        per_hit;

    // Pin event through two flops before use
    ctpw_event_sync u_sync (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .pin_in     (event_input_pin_in),
        .fall_out   (ev_fall)
    );

    // Compare values used directly, no shadow copy
    assign duty_v = {duty_compare_in.high, duty_compare_in.low};
    assign per_v  = {period_compare_in.high, period_compare_in.low};
    // Source select of the counting edge
    assign step   = (ctrl_in.ext_src == `CTPW_SRC_EXT) ? ev_fall : int_tick_in;
    assign duty_hit = (st_q.count == duty_v);
    // Warm-up ignores low compare byte
    assign per_hit  = (ctrl_in.warm_mode == `CTPW_MODE_WARM)
                      ? ((st_q.count & `CTPW_UPPER_MASK) == (per_v & `CTPW_UPPER_MASK))
                      : (st_q.count == per_v);

    // Next-state logic
    always_comb begin
        st_d     = st_q;
        st_d.irq = 1'b0;
        unique case (st_q.st)
            CTPW_ST_IDLE: begin
                // A new initial level after a stop re-arms the load
                if (ctrl_in.flop_initial_level != st_q.last_init) begin
                    st_d.run_seen = 1'b0;
                end
                // Stopped: flop follows initial level only in pulse mode
                if (ctrl_in.warm_mode == `CTPW_MODE_PPG && st_d.run_seen == 1'b0) begin
                    st_d.output_toggle_flop = ctrl_in.flop_initial_level;
                end
                if (ctrl_in.timer_run_bit) begin
                    st_d.st       = CTPW_ST_RUN;
                    st_d.count    = `CTPW_CNT_RST;
                    st_d.run_seen = 1'b0;
                end
            end
            CTPW_ST_RUN: begin
                if (!ctrl_in.timer_run_bit) begin
                    // Hold pin level at stop
                    st_d.st       = CTPW_ST_IDLE;
                    st_d.run_seen = 1'b1;
                end else if (step) begin
                    if (per_hit) begin
                        // Period match clears and interrupts
                        st_d.count = `CTPW_CNT_RST;
                        st_d.irq   = 1'b1;
                        if (ctrl_in.warm_mode == `CTPW_MODE_PPG) begin
                            st_d.output_toggle_flop = ~st_q.output_toggle_flop;
                        end
                    end else begin
                        // Up-count of the chained halves
                        st_d.count = st_q.count + `CTPW_CNT_ONE;
                        if (ctrl_in.warm_mode == `CTPW_MODE_PPG && duty_hit) begin
                            st_d.output_toggle_flop = ~st_q.output_toggle_flop;
                        end
                    end
                end
            end
            // Illegal one-hot code falls back to idle
            default: begin
                st_d.st = CTPW_ST_IDLE;
            end
        endcase
        // Level mirror for change detection after a stop
        st_d.last_init = ctrl_in.flop_initial_level;
        // Pin is the inverse of the flop
        st_d.pulse_n = ~st_d.output_toggle_flop;
    end

    // State register; reset clears the flop
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q.st                 <= CTPW_ST_IDLE;
            st_q.count              <= `CTPW_CNT_RST;
            st_q.output_toggle_flop <= `CTPW_FLOP_RST;
            st_q.irq                <= 1'b0;
            st_q.pulse_n            <= ~`CTPW_FLOP_RST;
            st_q.run_seen           <= 1'b0;
            st_q.last_init          <= `CTPW_FLOP_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse_output_n_out  = st_q.pulse_n;
    assign timer_match_irq_out = st_q.irq;
    assign count_out           = st_q.count;

    // Checks on the system clock, quiet during reset
    // Pin drive mirrors the flop inverted
    AST_PIN_INV: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        pulse_output_n_out == ~st_q.output_toggle_flop)
        else $error("pulse pin not inverse of flop");
    // Interrupt lasts exactly one cycle
    AST_IRQ_PULSE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        timer_match_irq_out |=> !timer_match_irq_out)
        else $error("interrupt longer than one cycle");
    // Interrupt only alongside a cleared counter
    AST_IRQ_CLR: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        timer_match_irq_out |-> count_out == `CTPW_CNT_RST)
        else $error("interrupt without counter clear");
    // Full period match in pulse mode interrupts and clears
    AST_PER_HIT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.timer_run_bit && step
         && ctrl_in.warm_mode == `CTPW_MODE_PPG && count_out == per_v)
        |=> (timer_match_irq_out && count_out == `CTPW_CNT_RST))
        else $error("period match missed");
    // Period match in pulse mode inverts the flop
    AST_PER_TOG: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.timer_run_bit && step
         && ctrl_in.warm_mode == `CTPW_MODE_PPG && count_out == per_v)
        |=> st_q.output_toggle_flop != $past(st_q.output_toggle_flop))
        else $error("period match did not toggle");
    // Duty match inverts the flop
    AST_DUTY_TOG: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.timer_run_bit && step && duty_hit && !per_hit
         && ctrl_in.warm_mode == `CTPW_MODE_PPG)
        |=> st_q.output_toggle_flop != $past(st_q.output_toggle_flop))
        else $error("duty match did not toggle");
    // Duty match keeps counting, with no clear and no interrupt
    AST_DUTY_KEEP: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.timer_run_bit && step && ctrl_in.warm_mode == `CTPW_MODE_PPG
         && count_out == duty_v && count_out != per_v)
        |=> (!timer_match_irq_out && count_out == $past(count_out) + `CTPW_CNT_ONE))
        else $error("duty match stopped the count");
    // A step without a period match advances the count
    AST_COUNT_UP: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.timer_run_bit && step && !per_hit)
        |=> count_out == $past(count_out) + `CTPW_CNT_ONE)
        else $error("counter did not advance");
    // No step, no change of count
    AST_NO_STEP_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.timer_run_bit && !step)
        |=> $stable(count_out))
        else $error("counter moved without a step");
    // Warm-up: upper byte match interrupts and clears
    AST_WARM_HIT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.timer_run_bit && step && ctrl_in.warm_mode == `CTPW_MODE_WARM
         && count_out[CNT_W-1:`CTPW_BYTE_W] == period_compare_in.high)
        |=> (timer_match_irq_out && count_out == `CTPW_CNT_RST))
        else $error("warm-up match missed");
    // Warm-up: the low byte alone never makes a match
    AST_WARM_LOW: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.timer_run_bit && step && ctrl_in.warm_mode == `CTPW_MODE_WARM
         && count_out[CNT_W-1:`CTPW_BYTE_W] != period_compare_in.high)
        |=> !timer_match_irq_out)
        else $error("warm-up match on low byte");
    // Warm-up leaves the flop alone
    AST_WARM_NOTOG: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && ctrl_in.warm_mode == `CTPW_MODE_WARM)
        |=> $stable(st_q.output_toggle_flop))
        else $error("flop moved in warm-up mode");
    // Stopping holds the pin
    AST_STOP_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_RUN && !ctrl_in.timer_run_bit)
        |=> $stable(pulse_output_n_out))
        else $error("pin changed on stop");
    // Stopped counter keeps its value
    AST_IDLE_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_IDLE && !ctrl_in.timer_run_bit) |=> $stable(count_out))
        else $error("counter moved while stopped");
    // Run bit from idle starts the count at zero
    AST_START_CLR: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_IDLE && ctrl_in.timer_run_bit)
        |=> (st_q.st == CTPW_ST_RUN && count_out == `CTPW_CNT_RST))
        else $error("start did not clear the counter");
    // No interrupt while stopped
    AST_IDLE_NO_IRQ: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        st_q.st == CTPW_ST_IDLE |-> !timer_match_irq_out)
        else $error("interrupt while stopped");
    // Interrupt only after a counting step
    AST_IRQ_CAUSE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        timer_match_irq_out |-> $past(step))
        else $error("interrupt without a step");
    // Armed flop takes the initial level while stopped
    AST_FLOP_LOAD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (st_q.st == CTPW_ST_IDLE && ctrl_in.warm_mode == `CTPW_MODE_PPG
         && (!st_q.run_seen || ctrl_in.flop_initial_level != st_q.last_init))
        |=> st_q.output_toggle_flop == $past(ctrl_in.flop_initial_level))
        else $error("flop did not load initial level");

endmodule // ctpw_timer

/* ctpw_params.svh */
// Constants for the cascaded timer with pulse and warm-up modes.
// Assumes inclusion by its bare name from the package and modules.
`ifndef CTPW_PARAMS_SVH
`define CTPW_PARAMS_SVH

// System clock period in ns (20 MHz)
`define CTPW_CLK_PERIOD_NS 50
// Counter width and byte width
`define CTPW_CNT_W         16
`define CTPW_BYTE_W        8
// Reset values
`define CTPW_CNT_RST       16'h0000
`define CTPW_FLOP_RST      1'b0
// Idle level of the event pin, used as synchroniser reset value
`define CTPW_PIN_IDLE      1'b1
// Counter step
`define CTPW_CNT_ONE       16'h0001
// Mode encodings on the mode port
`define CTPW_MODE_PPG      1'b0
`define CTPW_MODE_WARM     1'b1
// Warm-up compare keeps only the upper byte
`define CTPW_UPPER_MASK    16'hff00
// Clock source select encodings
`define CTPW_SRC_INT       1'b0
`define CTPW_SRC_EXT       1'b1

`endif

/* ctpw_pkg.sv */
// Types for the cascaded timer with pulse and warm-up modes.
// Assumes ctpw_params.svh is on the include path.
`include "ctpw_params.svh"

package ctpw_pkg;

    // Byte-wide compare values as written by software
    typedef struct packed {
        logic [`CTPW_BYTE_W-1:0] high;
        logic [`CTPW_BYTE_W-1:0] low;
    } ctpw_cmp_s;

    // Control bits from the timer control registers
    typedef struct packed {
        logic timer_run_bit;
        logic warm_mode;
        logic ext_src;
        logic flop_initial_level;
    } ctpw_ctrl_s;

    // Run state of the counter
    typedef enum logic [1:0] {
        CTPW_ST_IDLE = 2'b01,
        CTPW_ST_RUN  = 2'b10
    } ctpw_state_e;

    // Whole timer state
    typedef struct packed {
        ctpw_state_e             st;
        logic [`CTPW_CNT_W-1:0]  count;
        logic                    output_toggle_flop;
        logic                    irq;
        logic                    pulse_n;
        logic                    run_seen;
        logic                    last_init;
    } ctpw_state_s;

    // Edge detector state
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic fall;
    } ctpw_sync_s;

endpackage

/* ctpw_event_sync.sv */
// Event pin synchroniser and falling-edge detector.
// Assumes an asynchronous pin input and a single system clock.
`timescale 1ns/100ps
`include "ctpw_params.svh"

module ctpw_event_sync
    import ctpw_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    // Pin and edge pulse
    input  wire logic pin_in,
    output logic      fall_out
);

    ctpw_sync_s s_q;
    ctpw_sync_s s_d;

    // Two stages, then edge detect on the second stage only
    always_comb begin
        s_d      = s_q;
        s_d.s1   = pin_in;
        s_d.s2   = s_q.s1;
        s_d.prev = s_q.s2;
        s_d.fall = s_q.prev & ~s_q.s2;
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // Reset to the pin's idle level, so no false edge follows reset
            s_q <= '{s1: `CTPW_PIN_IDLE, s2: `CTPW_PIN_IDLE, prev: `CTPW_PIN_IDLE, fall: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign fall_out = s_q.fall;

endmodule // ctpw_event_sync

/* ctpw_event_src.sv */
// Model of the external event source on the counter's pin.
// Assumes the bench calls fire() from a falling clock edge.
`timescale 1ns/100ps

module ctpw_event_src #(
    parameter int HOLD = 8
) (
    // Clock and pin
    input  wire logic clk_sys_in,
    output logic      pin_out
);
    // Idle level high; only falling edges count
    initial pin_out = 1'b1;

    // Each level stands HOLD cycles, well past two machine cycles
    task automatic fire(input int n);
        repeat (n) begin
            @(negedge clk_sys_in);
            pin_out = 1'b0;
            repeat (HOLD) @(negedge clk_sys_in);
            pin_out = 1'b1;
            repeat (HOLD) @(negedge clk_sys_in);
        end
    endtask
endmodule // ctpw_event_src

/* ctpw_timer_tb_top.sv */
// Self-checking bench for the cascaded pulse and warm-up timer.
// Assumes ctpw_pkg and the event source model are compiled first.
`timescale 1ns/100ps

module ctpw_timer_tb_top
    import ctpw_pkg::*;
;
    logic        clk_sys_in;
    logic        nrst_in;
    ctpw_ctrl_s  ctrl;
    ctpw_cmp_s   duty;
    ctpw_cmp_s   period;
    logic        tick;
    logic        pin;
    logic        pulse_n;
    logic        irq;
    logic [15:0] count;
    logic [15:0] exp_cnt;
    logic        exp_flop;
    int          bad_count;
    int          checks;
    logic        port_latch;
    logic        ppg_pin;

    // Design and pin source
    ctpw_timer i_ctpw_timer (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ctrl_in(ctrl),
        .duty_compare_in(duty), .period_compare_in(period), .int_tick_in(tick),
        .event_input_pin_in(pin), .pulse_output_n_out(pulse_n),
        .timer_match_irq_out(irq), .count_out(count));
    ctpw_event_src i_ctpw_event_src (.clk_sys_in(clk_sys_in), .pin_out(pin));

    // Shared port: latch bit gates the timer's pin drive
    assign ppg_pin = pulse_n & port_latch;

    // 20 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Raise the run bit from idle; counter starts at zero
    task automatic start();
        ctrl.timer_run_bit = 1'b1;
        @(negedge clk_sys_in);
        exp_cnt = 16'h0000;
        chk(count, exp_cnt);
    endtask

    // Compare write, low byte then high byte
    task automatic set_period(input logic [15:0] v);
        period.low = v[7:0];
        @(negedge clk_sys_in);
        period.high = v[15:8];
    endtask

    // Internal ticks against a reference of both modes
    task automatic step(input int n);
        logic exp_irq;
        repeat (n) begin
            exp_irq = (exp_cnt[15:8] == period[15:8]) && (ctrl.warm_mode || exp_cnt[7:0] == period[7:0]);
            if (exp_irq) begin
                exp_cnt = 16'h0000;
                exp_flop = exp_flop ^ !ctrl.warm_mode;
            end else begin
                exp_flop = exp_flop ^ (exp_cnt == duty && !ctrl.warm_mode);
                exp_cnt = exp_cnt + 16'h0001;
            end
            tick = 1'b1;
            @(negedge clk_sys_in);
            tick = 1'b0;
            chk(count, exp_cnt);
            chk(ppg_pin, !exp_flop);
            chk(irq, exp_irq);
            @(negedge clk_sys_in);
            chk(irq, 16'h0000);
        end
    endtask

    // Main sequence
    initial begin
        nrst_in = 1'b0;
        ctrl = '0;
        duty = 16'h0003;
        period = 16'h0005;
        tick = 1'b0;
        bad_count = 0;
        checks = 0;
        port_latch = 1'b0;
        repeat (12) @(negedge clk_sys_in);
        chk(pulse_n, 16'h0001);
        nrst_in = 1'b1;
        port_latch = 1'b1;
        exp_flop = 1'b0;
        start();
        step(13);
        // Stop: ticks ignored, pin held
        ctrl.timer_run_bit = 1'b0;
        step(0);
        tick = 1'b1;
        @(negedge clk_sys_in);
        tick = 1'b0;
        @(negedge clk_sys_in);
        chk(count, exp_cnt);
        chk(pulse_n, !exp_flop);
        ctrl.flop_initial_level = 1'b1;
        @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        chk(pulse_n, 16'h0000);
        exp_flop = 1'b1;
        start();
        step(7);
        // Warm-up: level back to 0 after the stop, upper period byte only
        ctrl.timer_run_bit = 1'b0;
        @(negedge clk_sys_in);
        ctrl.flop_initial_level = 1'b0;
        @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        chk(ppg_pin, 16'h0001);
        ctrl.warm_mode = 1'b1;
        set_period(16'h01a5);
        @(negedge clk_sys_in);
        exp_flop = 1'b0;
        start();
        step(260);
        // Software stops the timer after the match, then pin edges count
        ctrl.timer_run_bit = 1'b0;
        @(negedge clk_sys_in);
        ctrl.warm_mode = 1'b0;
        ctrl.ext_src = 1'b1;
        set_period(16'h0100);
        @(negedge clk_sys_in);
        start();
        i_ctpw_event_src.fire(3);
        repeat (4) @(negedge clk_sys_in);
        chk(count, 16'h0003);
        report_and_stop();
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        bad_count++;
        report_and_stop();
    end
endmodule // ctpw_timer_tb_top
